/* File: shared/ddrsq_consts.svh */
// timing counts, widths and reset values of the ddr2 command sequencer
`ifndef DDRSQ_CONSTS_SVH
`define DDRSQ_CONSTS_SVH

`define DDRSQ_DQ_W 16
`define DDRSQ_SCHED_DEPTH 16
`define DDRSQ_BANKS 4
`define DDRSQ_BEAT_IDX_W 3
`define DDRSQ_BL4_CLKS 4'h2
`define DDRSQ_BL8_CLKS 4'h4
`define DDRSQ_BL4_LAST 3'h3
`define DDRSQ_BL8_LAST 3'h7
`define DDRSQ_GAP_SAT 4'h8
`define DDRSQ_SRX_RD_CLKS 200
`define DDRSQ_SRX_OTHER_CLKS 16
`define DDRSQ_SYNC_W 26

`endif

/* File: shared/ddrsq_pkg.sv */
// types shared by the ddr2 command sequencer
package ddrsq_pkg;
  typedef enum logic [2:0] {
    DDRSQ_ST_RUN = 3'b001,
    DDRSQ_ST_SELFREF = 3'b010,
    DDRSQ_ST_EXIT = 3'b100
  } ddrsq_state_t;
  typedef logic [1:0] ddrsq_bank_t;
endpackage

/* File: hw/ddrsq_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module ddrsq_sync #(
  parameter int W = 1
) (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // pins in, synchronised out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // next values: hold while the enable is low
  always_comb begin
    next_meta = i_ce ? i_async : meta;
    next_sync = i_ce ? meta : o_sync;
  end

  // registers, the first stage feeds only the second
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end
endmodule
`default_nettype wire

/* File: hw/ddrsq_top.sv */
// ddr2 device-side command sequencer: bursts, latencies and self refresh
//
// Overview of operation
// - with four-beat bursts a read is taken every second memory clock and the bursts leave without a gap.
// - with eight-beat bursts a read is taken every fourth memory clock and data leaves without idle beats.
// - back-to-back bursts work for the same or different banks as long as each addressed bank is open.
// - with four-beat bursts a write is taken every second memory clock and data is taken in without a gap.
// - with eight-beat bursts a write is taken every fourth memory clock and bursts are taken back to back.
`include "ddrsq_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module ddrsq_top #(
  parameter int DQ_W = `DDRSQ_DQ_W,
  parameter int SRX_RD_CLKS = `DDRSQ_SRX_RD_CLKS,
  parameter int SRX_OTHER_CLKS = `DDRSQ_SRX_OTHER_CLKS
) (
  // core clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // memory link pins
  input wire logic i_link_clk,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [1:0] i_bank,
  input wire logic i_addr10,
  input wire logic i_termination_control,
  input wire logic [15:0] i_wdata,
  // mode settings from same-domain logic
  input wire logic i_burst_length_8,
  input wire logic [2:0] i_additive_latency,
  input wire logic [2:0] i_column_access_latency,
  // data out and status
  output logic [15:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_dq_oe,
  output logic [15:0] o_wdata,
  output logic o_wdata_valid,
  output logic o_cmd_accept,
  output logic o_cmd_error,
  output logic o_selfref,
  output logic [3:0] o_bank_open,
  output logic o_term_active
);
  localparam int DEPTH = `DDRSQ_SCHED_DEPTH;
  localparam logic [15:0] SRX_RD_W = 16'(SRX_RD_CLKS);
  localparam logic [15:0] SRX_OTHER_W = 16'(SRX_OTHER_CLKS);

  logic [`DDRSQ_SYNC_W-1:0] pins_sync;
  logic s_link, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_a10, s_term;
  logic [1:0] s_bank;
  logic [15:0] s_wdata;

  // all pins pass two flip-flops first
  ddrsq_sync #(.W(`DDRSQ_SYNC_W)) u_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_async({i_link_clk, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank, i_addr10,
              i_termination_control, i_wdata}),
    .o_sync(pins_sync)
  );
  assign {s_link, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_a10, s_term, s_wdata} = pins_sync;

  ddrsq_pkg::ddrsq_state_t state, next_state;
  logic link_prev;
  logic [DEPTH-1:0] rd_sched, next_rd_sched, wr_sched, next_wr_sched;
  ddrsq_pkg::ddrsq_bank_t rd_bk [DEPTH];
  ddrsq_pkg::ddrsq_bank_t next_rd_bk [DEPTH];
  ddrsq_pkg::ddrsq_bank_t wr_bk [DEPTH];
  ddrsq_pkg::ddrsq_bank_t next_wr_bk [DEPTH];
  logic [2:0] rd_left, next_rd_left, wr_left, next_wr_left;
  logic [2:0] rd_beat, next_rd_beat, wr_beat, next_wr_beat;
  ddrsq_pkg::ddrsq_bank_t rd_bank, next_rd_bank, wr_bank, next_wr_bank;
  logic [3:0] gap, next_gap;
  logic [15:0] srx_cnt, next_srx_cnt;
  logic [15:0] next_rdata, next_wdata;
  logic next_rdata_valid, next_dq_oe, next_wdata_valid, next_cmd_accept, next_cmd_error;
  logic next_selfref, next_term_active;
  logic [3:0] next_bank_open;
  logic [15:0] mem [32];
  logic mem_we;
  logic [4:0] mem_wa;

  logic rise, fall, edge_any, sel, is_act, is_pre, is_rd, is_wr, is_ref;
  logic ok_rd, ok_other, rd_acc, wr_acc, rd_start, wr_start;
  logic [3:0] rl, wl, half;

  // edges of the sampled memory clock and command decode
  always_comb begin
    rise = s_link & ~link_prev;
    fall = ~s_link & link_prev;
    edge_any = rise | fall;
    sel = rise & ~s_cs_n;
    is_act = sel & ~s_ras_n & s_cas_n & s_we_n;
    is_pre = sel & ~s_ras_n & s_cas_n & ~s_we_n;
    is_rd = sel & s_ras_n & ~s_cas_n & s_we_n;
    is_wr = sel & s_ras_n & ~s_cas_n & ~s_we_n;
    is_ref = sel & ~s_ras_n & ~s_cas_n & s_we_n;
    rl = {1'b0, i_additive_latency} + {1'b0, i_column_access_latency};
    wl = rl - 4'h1;
    half = i_burst_length_8 ? `DDRSQ_BL8_CLKS : `DDRSQ_BL4_CLKS;
    ok_rd = (state == ddrsq_pkg::DDRSQ_ST_RUN) || (state == ddrsq_pkg::DDRSQ_ST_EXIT && srx_cnt >= SRX_RD_W);
    ok_other = (state == ddrsq_pkg::DDRSQ_ST_RUN) ||
               (state == ddrsq_pkg::DDRSQ_ST_EXIT && srx_cnt >= SRX_OTHER_W);
    rd_acc = is_rd && ok_rd && o_bank_open[s_bank] && gap >= half;
    wr_acc = is_wr && ok_other && o_bank_open[s_bank] && gap >= half;
    rd_start = rise & rd_sched[0];
    wr_start = rise & wr_sched[0];
  end

  // next state of commands, schedules, bursts and self refresh
  always_comb begin
    next_state = state;
    next_rd_sched = rd_sched;
    next_wr_sched = wr_sched;
    next_rd_bk = rd_bk;
    next_wr_bk = wr_bk;
    next_gap = gap;
    next_srx_cnt = srx_cnt;
    next_bank_open = o_bank_open;
    next_cmd_accept = 1'b0;
    next_cmd_error = 1'b0;
    next_rd_left = rd_left;
    next_rd_beat = rd_beat;
    next_rd_bank = rd_bank;
    next_wr_left = wr_left;
    next_wr_beat = wr_beat;
    next_wr_bank = wr_bank;
    next_rdata = o_rdata;
    next_rdata_valid = 1'b0;
    next_dq_oe = o_dq_oe;
    next_wdata = o_wdata;
    next_wdata_valid = 1'b0;
    mem_we = 1'b0;
    mem_wa = 5'h00;
    if (rise) begin
      // shift schedules one memory clock toward their start
      next_rd_sched = {1'b0, rd_sched[DEPTH-1:1]};
      next_wr_sched = {1'b0, wr_sched[DEPTH-1:1]};
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_rd_bk[i] = rd_bk[i+1];
        next_wr_bk[i] = wr_bk[i+1];
      end
      next_gap = (gap >= `DDRSQ_GAP_SAT) ? gap : gap + 4'h1;
      if (state == ddrsq_pkg::DDRSQ_ST_EXIT) begin
        next_srx_cnt = (srx_cnt == 16'hFFFF) ? srx_cnt : srx_cnt + 16'h0001;
      end
    end
    case (state)
      ddrsq_pkg::DDRSQ_ST_RUN, ddrsq_pkg::DDRSQ_ST_EXIT: begin
        if (state == ddrsq_pkg::DDRSQ_ST_EXIT && srx_cnt >= SRX_RD_W && srx_cnt >= SRX_OTHER_W) begin
          next_state = ddrsq_pkg::DDRSQ_ST_RUN;
        end
        if (rd_acc) begin
          next_rd_sched[rl[3:0] - 4'h1] = 1'b1;
          next_rd_bk[rl[3:0] - 4'h1] = s_bank;
          next_gap = 4'h1;
          next_cmd_accept = 1'b1;
        end else if (wr_acc) begin
          next_wr_sched[wl - 4'h1] = 1'b1;
          next_wr_bk[wl - 4'h1] = s_bank;
          next_gap = 4'h1;
          next_cmd_accept = 1'b1;
        end else if ((is_act || is_pre || is_ref) && ok_other) begin
          next_cmd_accept = 1'b1;
          if (is_act) begin
            next_cmd_error = o_bank_open[s_bank];
            next_bank_open[s_bank] = 1'b1;
          end else if (is_pre) begin
            next_bank_open = s_a10 ? 4'h0 : (o_bank_open & ~(4'h1 << s_bank));
          end else if (!s_cke) begin
            // self refresh entry, flagged if banks open or termination on
            next_cmd_error = (o_bank_open != 4'h0) || s_term;
            next_bank_open = 4'h0;
            next_state = ddrsq_pkg::DDRSQ_ST_SELFREF;
          end
        end else if (is_rd || is_wr || is_act || is_pre || is_ref) begin
          next_cmd_error = 1'b1;
        end
      end
      ddrsq_pkg::DDRSQ_ST_SELFREF: begin
        if (rise && s_cke) begin
          next_state = ddrsq_pkg::DDRSQ_ST_EXIT;
          next_srx_cnt = 16'h0000;
        end
      end
      default: next_state = ddrsq_pkg::DDRSQ_ST_RUN;
    endcase
    // read burst engine, one beat per memory clock edge
    if (rd_start) begin
      next_rd_left = i_burst_length_8 ? `DDRSQ_BL8_LAST : `DDRSQ_BL4_LAST;
      next_rd_beat = 3'h1;
      next_rd_bank = rd_bk[0];
      next_rdata = mem[{rd_bk[0], 3'h0}];
      next_rdata_valid = 1'b1;
      next_dq_oe = 1'b1;
    end else if (edge_any && rd_left != 3'h0) begin
      next_rd_left = rd_left - 3'h1;
      next_rd_beat = rd_beat + 3'h1;
      next_rdata = mem[{rd_bank, rd_beat}];
      next_rdata_valid = 1'b1;
    end else if (edge_any) begin
      next_dq_oe = 1'b0;
    end
    // write burst engine, stores each beat
    if (wr_start) begin
      next_wr_left = i_burst_length_8 ? `DDRSQ_BL8_LAST : `DDRSQ_BL4_LAST;
      next_wr_beat = 3'h1;
      next_wr_bank = wr_bk[0];
      mem_we = 1'b1;
      mem_wa = {wr_bk[0], 3'h0};
      next_wdata = s_wdata;
      next_wdata_valid = 1'b1;
    end else if (edge_any && wr_left != 3'h0) begin
      next_wr_left = wr_left - 3'h1;
      next_wr_beat = wr_beat + 3'h1;
      mem_we = 1'b1;
      mem_wa = {wr_bank, wr_beat};
      next_wdata = s_wdata;
      next_wdata_valid = 1'b1;
    end
    next_selfref = (next_state == ddrsq_pkg::DDRSQ_ST_SELFREF);
    next_term_active = s_term && (next_state == ddrsq_pkg::DDRSQ_ST_RUN);
  end

  // registers, frozen while the enable is low
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ddrsq_pkg::DDRSQ_ST_RUN;
      link_prev <= 1'b0;
      rd_sched <= '0;
      wr_sched <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        rd_bk[i] <= 2'h0;
        wr_bk[i] <= 2'h0;
      end
      rd_left <= 3'h0;
      rd_beat <= 3'h0;
      rd_bank <= 2'h0;
      wr_left <= 3'h0;
      wr_beat <= 3'h0;
      wr_bank <= 2'h0;
      gap <= `DDRSQ_GAP_SAT;
      srx_cnt <= 16'h0000;
      o_rdata <= 16'h0000;
      o_rdata_valid <= 1'b0;
      o_dq_oe <= 1'b0;
      o_wdata <= 16'h0000;
      o_wdata_valid <= 1'b0;
      o_cmd_accept <= 1'b0;
      o_cmd_error <= 1'b0;
      o_selfref <= 1'b0;
      o_bank_open <= 4'h0;
      o_term_active <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      link_prev <= s_link;
      rd_sched <= next_rd_sched;
      wr_sched <= next_wr_sched;
      rd_bk <= next_rd_bk;
      wr_bk <= next_wr_bk;
      rd_left <= next_rd_left;
      rd_beat <= next_rd_beat;
      rd_bank <= next_rd_bank;
      wr_left <= next_wr_left;
      wr_beat <= next_wr_beat;
      wr_bank <= next_wr_bank;
      gap <= next_gap;
      srx_cnt <= next_srx_cnt;
      o_rdata <= next_rdata;
      o_rdata_valid <= next_rdata_valid;
      o_dq_oe <= next_dq_oe;
      o_wdata <= next_wdata;
      o_wdata_valid <= next_wdata_valid;
      o_cmd_accept <= next_cmd_accept;
      o_cmd_error <= next_cmd_error;
      o_selfref <= next_selfref;
      o_bank_open <= next_bank_open;
      o_term_active <= next_term_active;
    end
  end

  // data storage, no reset needed
  always_ff @(posedge i_core_clk) begin
    if (i_ce && mem_we) begin
      mem[mem_wa] <= s_wdata;
    end
  end

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  AST_RD_GAPLESS: assert property ((o_rdata_valid && rd_left != 3'h0) |-> ##[1:8] o_rdata_valid)
    else $error("read burst has a gap");
  AST_RD_BL8_LOAD: assert property ((i_ce && rd_start && i_burst_length_8) |=> (rd_left == 3'h7))
    else $error("eight-beat read did not load seven more beats");
  AST_OPEN_BANK: assert property ((i_ce && state != ddrsq_pkg::DDRSQ_ST_SELFREF && (is_rd || is_wr) &&
    !o_bank_open[s_bank]) |=> (o_cmd_error && !o_cmd_accept))
    else $error("column command to a closed bank was not refused");
  AST_WR_GAPLESS: assert property ((o_wdata_valid && wr_left != 3'h0) |-> ##[1:8] o_wdata_valid)
    else $error("write burst has a gap");
  AST_WR_SPACING: assert property ((i_ce && wr_acc) |=> (gap == 4'h1)[*7])
    else $error("write spacing counter not restarted");
  AST_WL: assert property (wl + 4'h1 == rl)
    else $error("write latency is not read latency minus one");
  AST_RL_START: assert property ((i_ce && rd_start) |=> (o_rdata_valid && o_dq_oe))
    else $error("scheduled read start gave no data");
  AST_SPACING: assert property ((is_rd && gap < half) |=> !o_cmd_accept)
    else $error("read accepted too close to previous burst");
endmodule
`default_nettype wire

/* File: dv/ddrsq_ctrl_model.sv */
// behavioural ddr2 controller: link clock, command pins and write data
`timescale 1ns/100ps
`default_nettype none
module ddrsq_ctrl_model (
  // core clock that places the link edges
  input wire logic i_core_clk,
  // link pins towards the device
  output logic o_link_clk,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_bank,
  output logic o_addr10,
  output logic o_termination_control,
  output logic [15:0] o_wdata
);
  int ph = 0;
  int edge_no = 0;
  logic run = 1'b0;
  logic [15:0] wq [int];
  realtime etime [int];
  // idle levels before the first frame
  initial begin
    o_link_clk = 1'b0;
    o_cke = 1'b1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    o_bank = 2'h0;
    o_addr10 = 1'b0;
    o_termination_control = 1'b0;
    o_wdata = 16'h0000;
  end
  // link toggles every fourth core fall; data moves midway so it is stable at each edge
  always @(negedge i_core_clk) begin
    if (run) begin
      ph = ph + 1;
      if (ph % 4 == 0) begin
        edge_no = edge_no + 1;
        etime[edge_no] = $realtime;
        o_link_clk = ~o_link_clk;
      end else if (ph % 4 == 2) begin
        o_wdata = wq.exists(edge_no + 1) ? wq[edge_no + 1] : ~o_wdata;
      end
    end
  end
  // one command {cke,cs,ras,cas,we} held across one rising edge; returns its edge number
  task automatic cmd(input logic [4:0] code, input logic [1:0] bank, input logic a10, output int e);
    @(negedge o_link_clk);
    {o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n} = code;
    o_bank = bank;
    o_addr10 = a10;
    @(posedge o_link_clk);
    e = edge_no;
  endtask
  // deselected clocks; released lines show inverted levels, never the last ones
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge o_link_clk);
      o_cs_n = 1'b1;
      {o_ras_n, o_cas_n, o_we_n, o_bank} = ~{o_ras_n, o_cas_n, o_we_n, o_bank};
      @(posedge o_link_clk);
    end
  endtask
  // write command; beats follow on every edge from write_latency rises later
  task automatic wr(input logic [1:0] bank, input logic [15:0] base, input int wl, input int bl, output int e);
    cmd(5'h14, bank, 1'b0, e);
    for (int k = 0; k < bl; k++) wq[e + 2 * wl + k] = base + 16'(k);
  endtask
endmodule
`default_nettype wire

/* File: dv/test_ddr2_burst_and_self_refresh_timing.sv */
// self-checking bench for the ddr2 command sequencer
`timescale 1ns/100ps
`default_nettype none
module test_ddr2_burst_and_self_refresh_timing;
  localparam logic [4:0] ACT = 5'h13, PRE = 5'h12, RD = 5'h15, SRE = 5'h01, SRX = 5'h1F, REF = 5'h11;
  logic clk, nrst, ce, bl8, rv, oe, wv, acc, err, sref, tact;
  logic [2:0] al, cl;
  logic [3:0] bopen;
  logic [15:0] rdata, wdata;
  wire logic lclk, cke, cs_n, ras_n, cas_n, we_n, a10, term;
  wire logic [1:0] bank;
  wire logic [15:0] wd_pin;
  int fails, checks_done, acc_n, err_n, e;
  logic [15:0] rq[$], wq[$];
  realtime rt[$], wt[$];
  ddrsq_top #(.SRX_RD_CLKS(6), .SRX_OTHER_CLKS(2)) ddrsq_top_inst (
    .i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_link_clk(lclk), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank(bank), .i_addr10(a10),
    .i_termination_control(term), .i_wdata(wd_pin), .i_burst_length_8(bl8), .i_additive_latency(al),
    .i_column_access_latency(cl), .o_rdata(rdata), .o_rdata_valid(rv), .o_dq_oe(oe), .o_wdata(wdata),
    .o_wdata_valid(wv), .o_cmd_accept(acc), .o_cmd_error(err), .o_selfref(sref), .o_bank_open(bopen),
    .o_term_active(tact));
  ddrsq_ctrl_model ddrsq_ctrl_model_inst (
    .i_core_clk(clk), .o_link_clk(lclk), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_bank(bank), .o_addr10(a10), .o_termination_control(term), .o_wdata(wd_pin));
  // core clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // value compare, counted
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // captured beats: data, gapless spacing of one link half period, start after the latency edge
  task automatic chk_stream(ref logic [15:0] dq[$], ref realtime tq[$], input logic [15:0] exp[$], input realtime t0);
    chk(16'(dq.size()), 16'(exp.size()));
    foreach (exp[k]) begin
      chk(dq[k], exp[k]);
      if (k > 0) chk(16'(int'(tq[k] - tq[k - 1])), 16'h00C8);
    end
    chk({15'h0, (tq[0] - t0 >= 150) && (tq[0] - t0 <= 250)}, 16'h0001);
  endtask
  // capture strobes and beats at the falling edge, where they have settled
  always @(negedge clk) begin
    if (acc === 1'b1) acc_n++;
    if (err === 1'b1) err_n++;
    if (wv === 1'b1) begin
      wq.push_back(wdata);
      wt.push_back($realtime);
    end
    if (rv === 1'b1) begin
      rq.push_back(rdata);
      rt.push_back($realtime);
      chk({15'h0, oe}, 16'h0001);
    end
  end
  // two banks written then read back at the shortest spacing
  task automatic bursts(input logic b8, input logic [2:0] a, input logic [2:0] c);
    int e0, e1, rl, bl, a0, r0;
    logic [15:0] exp[$];
    bl8 = b8;
    al = a;
    cl = c;
    rl = int'(a) + int'(c);
    bl = b8 ? 8 : 4;
    a0 = acc_n;
    r0 = err_n;
    for (int k = 0; k < 2 * bl; k++) exp.push_back((k < bl ? 16'hA000 : 16'hB000) + 16'(k % bl));
    wq.delete();
    wt.delete();
    ddrsq_ctrl_model_inst.wr(2'h0, 16'hA000, rl - 1, bl, e0);
    ddrsq_ctrl_model_inst.idle(bl / 2 - 1);
    ddrsq_ctrl_model_inst.wr(2'h1, 16'hB000, rl - 1, bl, e1);
    ddrsq_ctrl_model_inst.idle(rl + bl);
    chk_stream(wq, wt, exp, ddrsq_ctrl_model_inst.etime[e0 + 2 * (rl - 1)]);
    rq.delete();
    rt.delete();
    ddrsq_ctrl_model_inst.cmd(RD, 2'h0, 1'b0, e0);
    ddrsq_ctrl_model_inst.idle(bl / 2 - 1);
    ddrsq_ctrl_model_inst.cmd(RD, 2'h1, 1'b0, e1);
    ddrsq_ctrl_model_inst.idle(rl + bl);
    chk_stream(rq, rt, exp, ddrsq_ctrl_model_inst.etime[e0 + 2 * rl]);
    chk(16'(acc_n - a0), 16'h0004);
    chk(16'(err_n - r0), 16'h0000);
    chk({15'h0, oe}, 16'h0000);
  endtask
  // a read one clock after another and a read to a closed bank are refused, an activate of an open bank is accepted but flagged
  task automatic refuse();
    int a0, r0;
    bl8 = 1'b0;
    a0 = acc_n;
    r0 = err_n;
    ddrsq_ctrl_model_inst.cmd(RD, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.cmd(RD, 2'h1, 1'b0, e);
    ddrsq_ctrl_model_inst.idle(1);
    ddrsq_ctrl_model_inst.cmd(RD, 2'h3, 1'b0, e);
    ddrsq_ctrl_model_inst.cmd(ACT, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.cmd(PRE, 2'h1, 1'b0, e);
    ddrsq_ctrl_model_inst.idle(12);
    chk(16'(acc_n - a0), 16'h0003);
    chk(16'(err_n - r0), 16'h0003);
    chk({12'h0, bopen}, 16'h0001);
  endtask
  // enable low freezes the block: a command sent meanwhile is lost, an auto refresh after it is taken
  task automatic freeze();
    int a0, r0;
    a0 = acc_n;
    r0 = err_n;
    ce = 1'b0;
    ddrsq_ctrl_model_inst.cmd(ACT, 2'h2, 1'b0, e);
    ddrsq_ctrl_model_inst.idle(2);
    chk({15'h0, acc}, 16'h0000);
    ce = 1'b1;
    ddrsq_ctrl_model_inst.idle(2);
    chk({12'h0, bopen}, 16'h0001);
    ddrsq_ctrl_model_inst.cmd(REF, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.idle(2);
    chk(16'(acc_n - a0), 16'h0001);
    chk(16'(err_n - r0), 16'h0000);
    chk({15'h0, sref}, 16'h0000);
  endtask
  // entry with banks closed and termination off, then the two exit delays
  task automatic selfref();
    int a0, r0;
    ddrsq_ctrl_model_inst.cmd(PRE, 2'h0, 1'b1, e);
    ddrsq_ctrl_model_inst.o_termination_control = 1'b0;
    ddrsq_ctrl_model_inst.idle(3);
    chk({12'h0, bopen}, 16'h0000);
    a0 = acc_n;
    r0 = err_n;
    ddrsq_ctrl_model_inst.cmd(SRE, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.idle(3);
    chk({15'h0, sref}, 16'h0001);
    ddrsq_ctrl_model_inst.cmd(SRX, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.cmd(ACT, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.idle(1);
    ddrsq_ctrl_model_inst.cmd(ACT, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.cmd(RD, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.idle(3);
    ddrsq_ctrl_model_inst.cmd(RD, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.o_termination_control = 1'b1;
    ddrsq_ctrl_model_inst.idle(12);
    chk({14'h0, sref, tact}, 16'h0001);
    chk(16'(acc_n - a0), 16'h0003);
    chk(16'(err_n - r0), 16'h0002);
  endtask
  // verdict and end of run
  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard
  initial begin
    #400us;
    fails++;
    wrap_up();
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    bl8 = 1'b0;
    al = 3'h2;
    cl = 3'h3;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk({10'h0, sref, tact, bopen}, 16'h0000);
    ddrsq_ctrl_model_inst.run = 1'b1;
    ddrsq_ctrl_model_inst.o_termination_control = 1'b1;
    ddrsq_ctrl_model_inst.cmd(ACT, 2'h0, 1'b0, e);
    ddrsq_ctrl_model_inst.cmd(ACT, 2'h1, 1'b0, e);
    ddrsq_ctrl_model_inst.idle(2);
    chk({11'h0, tact, bopen}, 16'h0013);
    bursts(1'b0, 3'h2, 3'h3);
    bursts(1'b1, 3'h1, 3'h3);
    refuse();
    freeze();
    selfref();
    wrap_up();
  end
endmodule
`default_nettype wire
